// *** ppm_defs.svh ***
// register offsets, field positions, reset values and widths of the progressive path mode bank
`ifndef PPM_DEFS_SVH
`define PPM_DEFS_SVH

`define PPM_ADDR_OUT_CTRL 8'h31
`define PPM_ADDR_DELAY_CTRL 8'h32
`define PPM_ADDR_FILT_CTRL 8'h33

`define PPM_RST_OUT_CTRL 8'h00
`define PPM_RST_DELAY_CTRL 8'h00
`define PPM_RST_FILT_CTRL 8'h68

`define PPM_BIT_PIX_VALID 0
`define PPM_BIT_TP_EN 2
`define PPM_BIT_TP_TYPE 3
`define PPM_LUMA_DLY_LSB 0
`define PPM_CHROMA_DLY_LSB 3
`define PPM_BIT_RED_FIRST 0
`define PPM_BIT_SINC_EN 3

`define PPM_DLY_W 3
`define PPM_MAX_DELAY 3'h4
`define PPM_PIX_W 10

`endif

// *** ppm_pkg.sv ***
// types shared by the progressive path mode bank
`include "ppm_defs.svh"
package ppm_pkg;
	typedef logic [`PPM_PIX_W-1:0] ppm_pix_t;
	typedef logic [`PPM_DLY_W-1:0] ppm_dly_t;
	typedef enum logic {PPM_PAT_HATCH, PPM_PAT_FLAT} ppm_pattern_e;
endpackage : ppm_pkg

// *** ppm_delay_if.sv ***
// carrier between the register bank and its luma and colour delay line
`timescale 1ns/1ps
interface ppm_delay_if;
	ppm_pkg::ppm_dly_t luma_code;
	ppm_pkg::ppm_dly_t chroma_code;
	logic sync_mark;
	ppm_pkg::ppm_pix_t luma_in;
	ppm_pkg::ppm_pix_t chroma_in;
	logic luma_start;
	logic chroma_start;
	ppm_pkg::ppm_pix_t luma_out;
	ppm_pkg::ppm_pix_t chroma_out;
	modport ctrl (output luma_code, chroma_code, sync_mark, luma_in, chroma_in,
		input luma_start, chroma_start, luma_out, chroma_out);
	modport line (input luma_code, chroma_code, sync_mark, luma_in, chroma_in,
		output luma_start, chroma_start, luma_out, chroma_out);
endinterface : ppm_delay_if

// *** ppm_delay_line.sv ***
// programmable 0..4 cycle delay of luma and colour paths behind the line sync edge
`timescale 1ns/1ps
`include "ppm_defs.svh"
module ppm_delay_line (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// settings and data
	ppm_delay_if.line dl
);
	localparam int TAPS = 5;
	logic [`PPM_PIX_W:0] luma_tap [TAPS];
	logic [`PPM_PIX_W:0] chroma_tap [TAPS];
	wire ppm_pkg::ppm_dly_t luma_sel;
	wire ppm_pkg::ppm_dly_t chroma_sel;

	// codes above four are unsupported; they clamp to the longest delay
	assign luma_sel = (dl.luma_code > `PPM_MAX_DELAY) ? `PPM_MAX_DELAY : dl.luma_code; // [R9]
	assign chroma_sel = (dl.chroma_code > `PPM_MAX_DELAY) ? `PPM_MAX_DELAY : dl.chroma_code; // [R9]

	assign luma_tap[0] = {dl.sync_mark, dl.luma_in};
	assign chroma_tap[0] = {dl.sync_mark, dl.chroma_in};

	genvar i;
	generate
		for (i = 1; i < TAPS; i++)
		begin : g_tap
			logic [`PPM_PIX_W:0] luma_r;
			logic [`PPM_PIX_W:0] chroma_r;
			always_ff @(posedge clk)
			begin
				if (!rst_n)
				begin
					luma_r <= '0;
					chroma_r <= '0;
				end
				else
				begin
					luma_r <= luma_tap[i-1];
					chroma_r <= chroma_tap[i-1];
				end
			end
			assign luma_tap[i] = luma_r;
			assign chroma_tap[i] = chroma_r;
		end
	endgenerate

	assign {dl.luma_start, dl.luma_out} = luma_tap[luma_sel]; // [R4]
	assign {dl.chroma_start, dl.chroma_out} = chroma_tap[chroma_sel]; // [R5]
endmodule : ppm_delay_line

// *** ppm_regs.sv ***
// progressive path mode registers with line-sync relative luma and colour delays
//
// Summary of operation
// [R1] Bit 0 of 0x31 turns pixel-data-valid handling on; register resets to 0x00.
// [R2] Bit 2 of 0x31 set enables the internal test pattern; cleared turns it off.
// [R3] Bit 3 of 0x31 picks pattern: clear gives hatch, set gives flat field.
// [R4] Bits 2:0 of 0x32 delay luma after line sync fall by 0 to 4 cycles.
// [R5] Bits 5:3 of 0x32 delay colour after line sync fall by 0 to 4 cycles.
// [R6] Bit 0 of 0x33 picks first chroma sample: blue when clear, red when set.
// [R7] Software writes zero to reserved bits 2:1 and 4 of 0x33.
// [R8] Bit 3 of 0x33 enables sinc filter on DACs 1 to 3; resets 0x68.
// [R9] Delay codes above 4 are unsupported; here they act as 4.
`timescale 1ns/1ps
`include "ppm_defs.svh"
module ppm_regs (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// video in
	input wire logic line_sync_n,
	input wire ppm_pkg::ppm_pix_t luma_in,
	input wire ppm_pkg::ppm_pix_t chroma_in,
	// video out
	output ppm_pkg::ppm_pix_t luma_out,
	output ppm_pkg::ppm_pix_t chroma_out,
	output logic luma_start,
	output logic chroma_start,
	output logic chroma_is_red,
	// mode controls
	output logic pixel_valid_en,
	output logic test_pattern_en,
	output ppm_pkg::ppm_pattern_e test_pattern_type,
	output logic sinc_filter_en
);
	logic [7:0] out_ctrl_r;
	logic [7:0] delay_ctrl_r;
	logic [7:0] filt_ctrl_r;
	logic sync_d_r;
	ppm_pkg::ppm_pix_t luma_out_r;
	ppm_pkg::ppm_pix_t chroma_out_r;
	logic luma_start_r;
	logic chroma_start_r;
	logic chroma_red_r;
	logic chroma_red_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic rvalid_r;

	ppm_delay_if dl ();

	wire wr_out = reg_wr && (reg_addr == `PPM_ADDR_OUT_CTRL);
	wire wr_dly = reg_wr && (reg_addr == `PPM_ADDR_DELAY_CTRL);
	wire wr_filt = reg_wr && (reg_addr == `PPM_ADDR_FILT_CTRL);
	wire sync_mark = sync_d_r && !line_sync_n;

	// register writes; all eight bits are held so reserved and untouched fields read back
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			out_ctrl_r <= `PPM_RST_OUT_CTRL; // [R1]
			delay_ctrl_r <= `PPM_RST_DELAY_CTRL;
			filt_ctrl_r <= `PPM_RST_FILT_CTRL; // [R8]
		end
		else
		begin
			if (wr_out)
				out_ctrl_r <= reg_wdata;
			if (wr_dly)
				delay_ctrl_r <= reg_wdata;
			if (wr_filt)
				filt_ctrl_r <= reg_wdata; // [R7]
		end
	end

	assign pixel_valid_en = out_ctrl_r[`PPM_BIT_PIX_VALID]; // [R1]
	assign test_pattern_en = out_ctrl_r[`PPM_BIT_TP_EN]; // [R2]
	assign test_pattern_type = ppm_pkg::ppm_pattern_e'(out_ctrl_r[`PPM_BIT_TP_TYPE]); // [R3]
	assign sinc_filter_en = filt_ctrl_r[`PPM_BIT_SINC_EN]; // [R8]

	// read decode, unmapped subaddresses read zero
	always_comb
	begin
		unique case (reg_addr)
			`PPM_ADDR_OUT_CTRL: rdata_nxt = out_ctrl_r;
			`PPM_ADDR_DELAY_CTRL: rdata_nxt = delay_ctrl_r;
			`PPM_ADDR_FILT_CTRL: rdata_nxt = filt_ctrl_r;
			default: rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end
		else
		begin
			rdata_r <= reg_rd ? rdata_nxt : rdata_r;
			rvalid_r <= reg_rd;
		end
	end

	assign reg_rdata = rdata_r;
	assign reg_rvalid = rvalid_r;

	// delay line feed
	assign dl.luma_code = delay_ctrl_r[`PPM_LUMA_DLY_LSB +: `PPM_DLY_W]; // [R4]
	assign dl.chroma_code = delay_ctrl_r[`PPM_CHROMA_DLY_LSB +: `PPM_DLY_W]; // [R5]
	assign dl.sync_mark = sync_mark;
	assign dl.luma_in = luma_in;
	assign dl.chroma_in = chroma_in;

	ppm_delay_line u_delay (
		.clk(clk),
		.rst_n(rst_n),
		.dl(dl.line)
	);

	// chroma phase restarts at the delayed line start, then alternates each sample
	assign chroma_red_nxt = dl.chroma_start ? filt_ctrl_r[`PPM_BIT_RED_FIRST] : !chroma_red_r; // [R6]

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sync_d_r <= 1'b1;
			luma_out_r <= '0;
			chroma_out_r <= '0;
			luma_start_r <= 1'b0;
			chroma_start_r <= 1'b0;
			chroma_red_r <= 1'b0;
		end
		else
		begin
			sync_d_r <= line_sync_n;
			luma_out_r <= dl.luma_out; // [R4]
			chroma_out_r <= dl.chroma_out; // [R5]
			luma_start_r <= dl.luma_start;
			chroma_start_r <= dl.chroma_start;
			chroma_red_r <= chroma_red_nxt;
		end
	end

	assign luma_out = luma_out_r;
	assign chroma_out = chroma_out_r;
	assign luma_start = luma_start_r;
	assign chroma_start = chroma_start_r;
	assign chroma_is_red = chroma_red_r;

	// checks
	sequence s_luma_code2;
		sync_mark && (delay_ctrl_r[2:0] == 3'h2) && !wr_dly;
	endsequence

	sequence s_chroma_code4;
		sync_mark && (delay_ctrl_r[5:3] == 3'h4) && !wr_dly;
	endsequence

	sequence s_luma_code7;
		sync_mark && (delay_ctrl_r[2:0] == 3'h7) && !wr_dly;
	endsequence

	sequence s_chroma_code5;
		sync_mark && (delay_ctrl_r[5:3] == 3'h5) && !wr_dly;
	endsequence

	// first colour sample of a line, with the order bit steady across the load
	sequence s_chroma_first;
		chroma_start && !$past(wr_filt) && !wr_filt;
	endsequence

	// first sample carries the programmed order, the next one the other colour
	sequence s_chroma_then_flip;
		(chroma_is_red == filt_ctrl_r[`PPM_BIT_RED_FIRST])
			##1 (chroma_start || (chroma_is_red != filt_ctrl_r[`PPM_BIT_RED_FIRST]));
	endsequence

	AST_OUT_CTRL_RESET: assert property (@(posedge clk) // [R1]
		$rose(rst_n) |-> (out_ctrl_r == 8'h00) && !pixel_valid_en)
		else $error("output control not zero after reset");

	AST_PIX_VALID_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
		wr_out |=> pixel_valid_en == $past(reg_wdata[0]))
		else $error("pixel data valid bit did not follow write");

	AST_TP_ENABLE: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
		wr_out ##1 !wr_out |-> test_pattern_en == $past(reg_wdata[2]))
		else $error("test pattern enable wrong");

	AST_TP_TYPE: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
		wr_out |=> (test_pattern_type == ppm_pkg::PPM_PAT_FLAT) == $past(reg_wdata[3]))
		else $error("test pattern type wrong");

	AST_LUMA_DELAY: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
		s_luma_code2 ##1 (!wr_dly)[*2] |=> luma_start && !$past(luma_start))
		else $error("luma start not three cycles after sync edge");

	AST_CHROMA_DELAY: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
		s_chroma_code4 ##1 (!wr_dly)[*4] |=> chroma_start)
		else $error("colour start not five cycles after sync edge");

	AST_CHROMA_ORDER: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
		s_chroma_first |-> s_chroma_then_flip)
		else $error("first chroma sample order wrong");

	AST_FILT_RESET: assert property (@(posedge clk) // [R8]
		$rose(rst_n) |-> filt_ctrl_r == 8'h68 && sinc_filter_en)
		else $error("filter control reset value wrong");

	AST_SINC_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
		wr_filt |=> sinc_filter_en == $past(reg_wdata[3]))
		else $error("sinc enable did not follow write");

	AST_DELAY_CLAMP: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
		s_luma_code7 ##1 (!wr_dly)[*4] |=> luma_start)
		else $error("oversize luma delay code not clamped to four");

	AST_CHROMA_CLAMP: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
		s_chroma_code5 ##1 (!wr_dly)[*4] |=> chroma_start)
		else $error("oversize colour delay code not clamped to four");
endmodule : ppm_regs

// *** progressive_path_mode_regs_bench.sv ***
// self-checking bench for the progressive path mode register bank
`timescale 1ns/1ps
module progressive_path_mode_regs_bench;
	logic clk;
	logic rst_n;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic line_sync_n;
	ppm_pkg::ppm_pix_t luma_in;
	ppm_pkg::ppm_pix_t chroma_in;
	ppm_pkg::ppm_pix_t luma_out;
	ppm_pkg::ppm_pix_t chroma_out;
	logic luma_start;
	logic chroma_start;
	logic chroma_is_red;
	logic pixel_valid_en;
	logic test_pattern_en;
	ppm_pkg::ppm_pattern_e test_pattern_type;
	logic sinc_filter_en;
	int miscompares;
	int n_compared;
	int i;

	ppm_regs dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.reg_rvalid, .line_sync_n, .luma_in, .chroma_in, .luma_out, .chroma_out,
		.luma_start, .chroma_start, .chroma_is_red, .pixel_valid_en, .test_pattern_en,
		.test_pattern_type, .sinc_filter_en);

	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic complete_run;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		@(negedge clk);
	endtask : wr

	// read valid stands for exactly one cycle after the taking edge; the data holds until the next read
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		chk(reg_rvalid, 1'b1);
		chk(reg_rdata, exp);
		@(negedge clk);
		chk(reg_rvalid, 1'b0);
	endtask : rdchk

	// one line start: measure both start delays and the sample carried with them
	task automatic run_line(input logic [2:0] lc, input logic [2:0] cc, input logic red);
		int n;
		int ln;
		int cn;
		ln = 0;
		cn = 0;
		wr(8'h32, {2'h0, cc, lc});
		line_sync_n = 1'b0;
		for (n = 1; n <= 8; n++)
		begin
			luma_in = 10'h100 + 10'(n);
			chroma_in = 10'h200 + 10'(n);
			@(negedge clk);
			line_sync_n = 1'b1;
			if (luma_start === 1'b1)
			begin
				ln = n;
				chk(luma_out, 10'h101);
			end
			if (chroma_start === 1'b1)
			begin
				cn = n;
				chk(chroma_out, 10'h201);
				chk(chroma_is_red, red);
			end
		end
		// oversize codes act as the longest delay of four
		chk(10'(ln), (lc > 3'h4) ? 10'h005 : 10'(lc) + 10'h1);
		chk(10'(cn), (cc > 3'h4) ? 10'h005 : 10'(cc) + 10'h1);
	endtask : run_line

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial
	begin
		miscompares = 0;
		n_compared = 0;
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		line_sync_n = 1'b1;
		luma_in = 10'h000;
		chroma_in = 10'h000;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		rdchk(8'h31, 8'h00);
		rdchk(8'h32, 8'h00);
		rdchk(8'h33, 8'h68);
		chk(sinc_filter_en, 1'b1);
		$display("test reset values done");
		wr(8'h31, 8'h0d);
		chk({pixel_valid_en, test_pattern_en, test_pattern_type}, 3'b111);
		wr(8'h31, 8'h04);
		chk({pixel_valid_en, test_pattern_en, test_pattern_type}, 3'b010);
		wr(8'h31, 8'h08);
		chk({pixel_valid_en, test_pattern_en, test_pattern_type}, 3'b001);
		rdchk(8'h31, 8'h08);
		rdchk(8'h40, 8'h00);
		$display("test mode bits done");
		// every supported code on both paths, luma and colour set apart except at code 2
		for (i = 0; i < 5; i++)
			run_line(3'(i), 3'(4 - i), 1'b0);
		run_line(3'h7, 3'h5, 1'b0);
		$display("test delays done");
		// reserved bits of the filter register are written as zero
		wr(8'h33, 8'h61);
		chk(sinc_filter_en, 1'b0);
		run_line(3'h4, 3'h0, 1'b1);
		wr(8'h33, 8'h68);
		chk(sinc_filter_en, 1'b1);
		run_line(3'h0, 3'h4, 1'b0);
		rdchk(8'h33, 8'h68);
		$display("test chroma order done");
		complete_run();
	end
endmodule : progressive_path_mode_regs_bench
